// ==== hdl/rx_port_pkg.sv ====
// constants and state types for the receive output port
package rx_port_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int TRAIN_PERIOD_NS = 800;
	localparam int TRAIN_PERIOD_CYCLES = TRAIN_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [3:0] TRAIN_NOMINAL = 4'(TRAIN_PERIOD_CYCLES);
	localparam logic [3:0] TRAIN_TOL = 4'h1;
	localparam logic [3:0] TRAIN_CNT_MAX = 4'hF;
	localparam logic [2:0] CHAR_LAST = 3'h7;
	localparam logic [2:0] CHAR_HALF = 3'h3;
	localparam logic [2:0] RECLK_RISE = 3'h1;
	localparam logic [2:0] RECLK_FALL = 3'h5;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_INT_STATUS = 8'h08;
	localparam logic [7:0] OFS_INT_MASK = 8'h0C;
	// control register fields
	localparam int CTRL_RATE = 0;
	localparam int CTRL_TEST_LO = 1;
	localparam int CTRL_ROE1 = 3;
	localparam int CTRL_ROE2 = 4;
	// status register fields
	localparam int STAT_PD = 0;
	localparam int STAT_RANGE = 1;
	localparam int STAT_CHK_LO = 2;
	// interrupt bits
	localparam int INT_CHK_ERR = 0;
	localparam int INT_CHK_PASS = 1;
	localparam int INT_RANGE_LOST = 2;
	localparam int INT_PD_CHANGE = 3;
	// reset values and the checker test field code
	localparam logic [1:0] TEST_FIELD_RESET = 2'h0;
	localparam logic [1:0] TEST_FIELD_CHECK = 2'h2;
	localparam logic [3:0] INT_MASK_RESET = 4'h0;
	localparam logic ROE_RESET = 1'b1;
	// checker status codes on the low character bits, last pattern value, bus response codes
	localparam logic [1:0] CHK_GOOD = 2'h0;
	localparam logic [1:0] CHK_BAD = 2'h1;
	localparam logic [1:0] CHK_IDLE = 2'h3;
	localparam logic [9:0] PATTERN_LAST = 10'h3FF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef struct packed {
		logic [9:0] expected;
		logic [1:0] code;
		logic pin;
		logic err_pulse;
		logic pass_pulse;
	} checker_state_t;

	typedef struct packed {
		logic [2:0] div_cnt;
		logic rx_clk_p;
		logic rx_clk_n;
		logic reclk;
		logic [9:0] char_out;
		logic status_pin;
		logic pd_flag;
		logic rate_sel;
		logic [1:0] test_field;
		logic roe1;
		logic roe2;
		logic [3:0] int_status;
		logic [3:0] int_mask;
		logic irq;
		logic trg_s1;
		logic trg_s2;
		logic trg_s3;
		logic trg_stable;
		logic [3:0] trg_cnt;
		logic range_ok;
		wr_state_t wr_state;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} port_state_t;
endpackage : rx_port_pkg

// ==== hdl/pattern_checker.sv ====
// character pattern checker feeding status onto the output port
`timescale 1ns/1ps
module pattern_checker (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic enable, // checker running
	input wire logic tick, // one pulse per character
	input wire logic [9:0] char_in, // received character
	output logic [1:0] code, // status code for low bits
	output logic pin, // end of pattern reached
	output logic err_pulse, // mismatch seen
	output logic pass_pulse // full pattern seen
);
	rx_port_pkg::checker_state_t s;
	rx_port_pkg::checker_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.err_pulse = 1'b0;
		next_s.pass_pulse = 1'b0;
		if (!enable) begin
			next_s.expected = 10'h000;
			next_s.code = rx_port_pkg::CHK_IDLE;
			next_s.pin = 1'b0;
		end else if (tick) begin
			if (char_in == s.expected) begin
				next_s.code = rx_port_pkg::CHK_GOOD;
				next_s.expected = s.expected + 10'h001;
				next_s.pin = (s.expected == rx_port_pkg::PATTERN_LAST);
				next_s.pass_pulse = (s.expected == rx_port_pkg::PATTERN_LAST);
			end else begin
				// resync on the received value so one error is not counted forever
				next_s.code = rx_port_pkg::CHK_BAD;
				next_s.expected = char_in + 10'h001;
				next_s.pin = 1'b0;
				next_s.err_pulse = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{expected: 10'h000, code: rx_port_pkg::CHK_IDLE, pin: 1'b0,
				err_pulse: 1'b0, pass_pulse: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign code = s.code;
	assign pin = s.pin;
	assign err_pulse = s.err_pulse;
	assign pass_pulse = s.pass_pulse;
endmodule : pattern_checker

// ==== hdl/rx_output_port.sv ====
// receive output port: character clocking, checker status, reclock clock, register slave
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - full rate: data change on true rising
// - half rate: clock halves, data both edges
// - checker on: status on bits 1:0
// - status pin valid only for field 10
// - power-down flag when both enables zero
// - training clock is frequency detector reference
// - receive clock continuous, rate by select
// - reclock clock at char clock, not rate scaled
// - reset initialises all state
// - reset leaves test controller alone
module rx_output_port (
	input wire logic aclk, // system clock, 10 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [9:0] rx_char_in, // recovered character, aclk domain
	input wire logic training_reference_clock, // training clock pin, asynchronous
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [9:0] rx_char_out, // parallel character output
	output logic recovered_output_clock_p, // receive clock, true
	output logic recovered_output_clock_n, // receive clock, complement
	output logic checker_status_pin, // checker status pin
	output logic reclock_powered_down_flag, // reclocker powered down
	output logic reclocker_clock_out, // reclocker clock
	output logic irq // level interrupt
);
	rx_port_pkg::port_state_t s;
	rx_port_pkg::port_state_t next_s;

	logic chk_enable;
	logic char_tick;
	logic [1:0] chk_code;
	logic chk_pin;
	logic chk_err;
	logic chk_pass;

	assign chk_enable = (s.test_field == rx_port_pkg::TEST_FIELD_CHECK);
	// one character per divider wrap
	assign char_tick = (s.div_cnt == rx_port_pkg::CHAR_LAST);

	pattern_checker i_pattern_checker (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(chk_enable),
		.tick(char_tick),
		.char_in(rx_char_in),
		.code(chk_code),
		.pin(chk_pin),
		.err_pulse(chk_err),
		.pass_pulse(chk_pass)
	);

	always_comb begin
		logic trg_rise;
		logic [3:0] period;
		logic range_now;
		logic pd_now;
		logic [3:0] events;
		logic [3:0] clr;
		logic wr_ok;
		logic [31:0] rd;
		logic [1:0] rresp;
		trg_rise = 1'b0;
		period = 4'h0;
		range_now = 1'b0;
		pd_now = 1'b0;
		events = 4'h0;
		clr = 4'h0;
		wr_ok = 1'b0;
		rd = 32'h0000_0000;
		rresp = rx_port_pkg::RESP_OKAY;
		next_s = s;

		// character divider runs free so the receive clock never stops
		next_s.div_cnt = s.div_cnt + 3'h1;

		if (s.rate_sel == 1'b0) begin
			// rising true edge with new data
			// toggle, not set: a late switch from half rate must still give an edge
			if (char_tick) begin
				next_s.rx_clk_p = !s.rx_clk_p;
				next_s.rx_clk_n = s.rx_clk_p;
			end else if (s.div_cnt == rx_port_pkg::CHAR_HALF) begin
				next_s.rx_clk_p = 1'b0;
				next_s.rx_clk_n = 1'b1;
			end
		end else begin
			if (char_tick) begin
				next_s.rx_clk_p = !s.rx_clk_p;
				next_s.rx_clk_n = s.rx_clk_p;
			end
		end

		// characters move with the clock edge
		if (char_tick) begin
			if (chk_enable) begin
				// status in low bits, upper bits zero
				next_s.char_out = {8'h00, chk_code};
			end else begin
				next_s.char_out = rx_char_in;
			end
		end
		// pin carries status only for field 10
		next_s.status_pin = chk_enable ? chk_pin : 1'b0;

		// both enables off powers reclocker down
		pd_now = !s.roe1 && !s.roe2;
		next_s.pd_flag = pd_now;

		// reclock clock at character rate
		// offset phase: same as receive clock at full rate, twice it at half rate
		if (pd_now) begin
			next_s.reclk = 1'b0;
		end else if (s.div_cnt == rx_port_pkg::RECLK_RISE) begin
			next_s.reclk = 1'b1;
		end else if (s.div_cnt == rx_port_pkg::RECLK_FALL) begin
			next_s.reclk = 1'b0;
		end

		// training clock: three stages, change taken once stages two and three agree
		next_s.trg_s1 = training_reference_clock;
		next_s.trg_s2 = s.trg_s1;
		next_s.trg_s3 = s.trg_s2;
		if (s.trg_s2 == s.trg_s3) begin
			next_s.trg_stable = s.trg_s3;
			trg_rise = s.trg_s3 && !s.trg_stable;
		end

		period = s.trg_cnt + 4'h1;
		if (trg_rise) begin
			next_s.trg_cnt = 4'h0;
			if (period >= rx_port_pkg::TRAIN_NOMINAL) begin
				range_now = (period - rx_port_pkg::TRAIN_NOMINAL) <= rx_port_pkg::TRAIN_TOL;
			end else begin
				range_now = (rx_port_pkg::TRAIN_NOMINAL - period) <= rx_port_pkg::TRAIN_TOL;
			end
			next_s.range_ok = range_now;
		end else if (s.trg_cnt == rx_port_pkg::TRAIN_CNT_MAX) begin
			// stalled reference reads as out of range
			next_s.range_ok = 1'b0;
		end else begin
			next_s.trg_cnt = period;
		end

		events[rx_port_pkg::INT_CHK_ERR] = chk_err;
		events[rx_port_pkg::INT_CHK_PASS] = chk_pass;
		events[rx_port_pkg::INT_RANGE_LOST] = s.range_ok && !next_s.range_ok;
		events[rx_port_pkg::INT_PD_CHANGE] = pd_now != s.pd_flag;

		// write channel: address and data taken in either order
		if (s.awready && s_axi_awvalid) begin
			next_s.awready = 1'b0;
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.wready = 1'b0;
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		case (s.wr_state)
			rx_port_pkg::WR_IDLE: begin
				if (s.aw_got && s.w_got) begin
					wr_ok = 1'b1;
					next_s.bvalid = 1'b1;
					next_s.wr_state = rx_port_pkg::WR_RESP;
					next_s.bresp = rx_port_pkg::RESP_OKAY;
					case (s.awaddr)
						rx_port_pkg::OFS_CTRL: begin
							if (s.wstrb[0]) begin
								next_s.rate_sel = s.wdata[rx_port_pkg::CTRL_RATE];
								next_s.test_field = s.wdata[rx_port_pkg::CTRL_TEST_LO +: 2];
								next_s.roe1 = s.wdata[rx_port_pkg::CTRL_ROE1];
								next_s.roe2 = s.wdata[rx_port_pkg::CTRL_ROE2];
							end
						end
						rx_port_pkg::OFS_STATUS: begin
						end
						rx_port_pkg::OFS_INT_STATUS: begin
							if (s.wstrb[0]) begin
								clr = s.wdata[3:0];
							end
						end
						rx_port_pkg::OFS_INT_MASK: begin
							if (s.wstrb[0]) begin
								next_s.int_mask = s.wdata[3:0];
							end
						end
						default: begin
							next_s.bresp = rx_port_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			rx_port_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					next_s.bvalid = 1'b0;
					next_s.aw_got = 1'b0;
					next_s.w_got = 1'b0;
					next_s.awready = 1'b1;
					next_s.wready = 1'b1;
					next_s.wr_state = rx_port_pkg::WR_IDLE;
				end
			end
			default: begin
				next_s.wr_state = rx_port_pkg::WR_IDLE;
			end
		endcase

		// sticky status: a new event wins over a same-cycle clear
		next_s.int_status = (s.int_status & ~(wr_ok ? clr : 4'h0)) | events;
		next_s.irq = |(next_s.int_status & next_s.int_mask);

		// read channel, one read at a time
		// address decoded live; the master holds it until taken
		case (s_axi_araddr)
			rx_port_pkg::OFS_CTRL: begin
				rd[rx_port_pkg::CTRL_RATE] = s.rate_sel;
				rd[rx_port_pkg::CTRL_TEST_LO +: 2] = s.test_field;
				rd[rx_port_pkg::CTRL_ROE1] = s.roe1;
				rd[rx_port_pkg::CTRL_ROE2] = s.roe2;
			end
			rx_port_pkg::OFS_STATUS: begin
				rd[rx_port_pkg::STAT_PD] = s.pd_flag;
				rd[rx_port_pkg::STAT_RANGE] = s.range_ok;
				rd[rx_port_pkg::STAT_CHK_LO +: 3] = {chk_pin, chk_code};
			end
			rx_port_pkg::OFS_INT_STATUS: begin
				rd[3:0] = s.int_status;
			end
			rx_port_pkg::OFS_INT_MASK: begin
				rd[3:0] = s.int_mask;
			end
			default: begin
				rresp = rx_port_pkg::RESP_SLVERR;
			end
		endcase
		if (s.arready && s_axi_arvalid) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = rd;
			next_s.rresp = rresp;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	// no test controller state lives here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{
				// character path and clocks
				div_cnt: 3'h0,
				rx_clk_p: 1'b0,
				rx_clk_n: 1'b1,
				reclk: 1'b0,
				char_out: 10'h000,
				status_pin: 1'b0,
				pd_flag: 1'b0,
				// configuration, enables on so the reclocker starts powered
				rate_sel: 1'b0,
				test_field: rx_port_pkg::TEST_FIELD_RESET,
				roe1: rx_port_pkg::ROE_RESET,
				roe2: rx_port_pkg::ROE_RESET,
				// interrupts
				int_status: 4'h0,
				int_mask: rx_port_pkg::INT_MASK_RESET,
				irq: 1'b0,
				// training reference
				trg_s1: 1'b0,
				trg_s2: 1'b0,
				trg_s3: 1'b0,
				trg_stable: 1'b0,
				trg_cnt: 4'h0,
				range_ok: 1'b0,
				// write channel
				wr_state: rx_port_pkg::WR_IDLE,
				awready: 1'b1,
				wready: 1'b1,
				aw_got: 1'b0,
				w_got: 1'b0,
				awaddr: 8'h00,
				wdata: 32'h0000_0000,
				wstrb: 4'h0,
				bvalid: 1'b0,
				bresp: 2'h0,
				// read channel
				arready: 1'b1,
				rvalid: 1'b0,
				rdata: 32'h0000_0000,
				rresp: 2'h0
			};
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
	assign rx_char_out = s.char_out;
	assign recovered_output_clock_p = s.rx_clk_p;
	assign recovered_output_clock_n = s.rx_clk_n;
	assign checker_status_pin = s.status_pin;
	assign reclock_powered_down_flag = s.pd_flag;
	assign reclocker_clock_out = s.reclk;
	assign irq = s.irq;
endmodule : rx_output_port

// ==== sim/rx_output_port_props.sv ====
// pin-level assertions for the receive output port
`timescale 1ns/1ps
module rx_output_port_props (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [9:0] rx_char_out, // characters
	input wire logic recovered_output_clock_p, // clock true
	input wire logic recovered_output_clock_n, // clock complement
	input wire logic checker_status_pin, // checker pin
	input wire logic reclock_powered_down_flag, // power-down flag
	input wire logic reclocker_clock_out, // reclock clock
	input wire logic irq // interrupt
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	clk_pair_a: assert property (
		recovered_output_clock_n == !recovered_output_clock_p) else $error("clock pair not complementary");
	data_on_edge_a: assert property (
		$changed(rx_char_out) |-> $changed(recovered_output_clock_p)) else $error("data moved off clock edge");
	clk_running_a: assert property (
		1'b1 |-> ##[1:8] $changed(recovered_output_clock_p)) else $error("receive clock stopped");
	chk_high_bits_a: assert property (
		checker_status_pin |-> rx_char_out[9:2] == 8'h00) else $error("high bits set in checker mode");
	pd_quiet_a: assert property (
		reclock_powered_down_flag [*2] |-> !reclocker_clock_out) else $error("reclock clock runs powered down");
	reclk_shape_a: assert property (disable iff (!aresetn || reclock_powered_down_flag)
		$rose(reclocker_clock_out) |-> reclocker_clock_out [*4] ##1 !reclocker_clock_out)
		else $error("reclock clock shape wrong");
	reset_state_a: assert property (disable iff (1'b0)
		!aresetn |=> !recovered_output_clock_p && recovered_output_clock_n && rx_char_out == 10'h000
		&& !checker_status_pin && !reclock_powered_down_flag && !reclocker_clock_out && !irq)
		else $error("outputs not at reset state");
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule : rx_output_port_props
bind rx_output_port rx_output_port_props i_rx_output_port_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rx_char_out, .recovered_output_clock_p, .recovered_output_clock_n,
	.checker_status_pin, .reclock_powered_down_flag, .reclocker_clock_out, .irq);

// ==== sim/host_capture.sv ====
// host logic capturing parallel characters
`timescale 1ns/1ps
module host_capture (
	input wire logic aclk, // system clock
	input wire logic half, // host set for half rate
	input wire logic test_on, // checker mode active
	input wire logic clk_p, // receive clock, true
	input wire logic [9:0] data, // character pins
	output logic cap, // capture strobe
	output logic [9:0] cap_data // captured character
);
	logic last_p = 1'b0;
	// nothing derived from training or reclock clock
	always_ff @(posedge aclk) begin
		last_p <= clk_p;
		cap <= 1'b0;
		if (clk_p != last_p && (clk_p || half)) begin
			cap <= 1'b1;
			cap_data <= test_on ? {8'h00, data[1:0]} : data;
		end
	end
endmodule : host_capture

// ==== sim/deser_rx_output_status_port_tb_top.sv ====
// self-checking bench for the receive output port
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", n, e, a); end end
module deser_rx_output_status_port_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, train_on = 1'b1, training_reference_clock = 1'b0;
	logic [9:0] rx_char_in = 10'h000;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [9:0] rx_char_out, cap_data;
	logic recovered_output_clock_p, recovered_output_clock_n, checker_status_pin;
	logic reclock_powered_down_flag, reclocker_clock_out, cap;
	logic half = 0, test_on = 0, cmp_on = 0, p_last = 0, r_last = 0, pin_seen = 0;
	logic [1:0] fields [3] = '{2'h0, 2'h1, 2'h3};
	logic [7:0] pc = 8'h00, rc = 8'h00;
	int bad_count = 0, checks_done = 0;
	initial forever #50 aclk = ~aclk;
	// link clock free of the system clock phase
	initial begin
		#17;
		forever begin
			#400;
			if (train_on) training_reference_clock = ~training_reference_clock;
		end
	end
	rx_output_port i_rx_output_port (.aclk, .aresetn, .rx_char_in, .training_reference_clock, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rx_char_out, .recovered_output_clock_p, .recovered_output_clock_n,
		.checker_status_pin, .reclock_powered_down_flag, .reclocker_clock_out, .irq);
	host_capture i_host_capture (.aclk, .half, .test_on, .clk_p(recovered_output_clock_p), .data(rx_char_out),
		.cap, .cap_data);
	// new character only once the host took the last one
	always @(posedge aclk) begin
		p_last <= recovered_output_clock_p;
		r_last <= reclocker_clock_out;
		pc <= pc + 8'h01;
		rc <= rc + 8'h01;
		if (checker_status_pin) pin_seen <= 1'b1;
		if (recovered_output_clock_p && !p_last) begin
			pc <= 8'h01;
			if (cmp_on) `CHK("clock period", half ? 8'h10 : 8'h08, pc)
		end
		if (reclocker_clock_out && !r_last) begin
			rc <= 8'h01;
			if (cmp_on) `CHK("reclock period", 8'h08, rc)
		end
		if (cap) begin
			if (cmp_on && !test_on) `CHK("character", rx_char_in, cap_data)
			if (cmp_on && test_on) `CHK("checker code", {8'h00, rx_port_pkg::CHK_GOOD}, rx_char_out)
			rx_char_in <= test_on ? rx_char_in + 10'h001 : 10'($urandom);
		end
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		`CHK("bresp", er, s_axi_bresp)
		@(posedge aclk);
	endtask : axw
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
		`CHK(n, e, rd & m)
		@(posedge aclk);
	endtask : rchk
	task automatic settle(input int n);
		cmp_on <= 0;
		repeat (n) @(posedge aclk);
		cmp_on <= 1;
	endtask : settle
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		#3000000;
		bad_count++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h58fd_e1f5));
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rchk("ctrl", rx_port_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0018);
		rchk("mask", rx_port_pkg::OFS_INT_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
		rchk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
		`CHK("rresp", rx_port_pkg::RESP_SLVERR, rsp)
		axw(8'h10, 32'h0000_0001, rx_port_pkg::RESP_SLVERR);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			cmp_on <= 0;
			half <= i[0];
			axw(rx_port_pkg::OFS_CTRL, {31'h0000_000C, i[0]}, rx_port_pkg::RESP_OKAY);
			settle(40);
			repeat (150 + $urandom_range(100)) @(posedge aclk);
		end
		rchk("range ok", rx_port_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
		$display("test rates done");
		cmp_on <= 0;
		half <= 0;
		for (int i = 0; i < 4; i++) begin
			axw(rx_port_pkg::OFS_CTRL, {27'h000_0000, i[1:0], 3'h0}, rx_port_pkg::RESP_OKAY);
			repeat (4) @(posedge aclk);
			`CHK("pd flag", i == 0, reclock_powered_down_flag)
			rchk("pd status", rx_port_pkg::OFS_STATUS, 32'h0000_0001, {31'h0, i == 0});
		end
		rchk("pd event", rx_port_pkg::OFS_INT_STATUS, 32'h0000_0008, 32'h0000_0008);
		axw(rx_port_pkg::OFS_INT_STATUS, 32'h0000_000F, rx_port_pkg::RESP_OKAY);
		$display("test power-down done");
		test_on <= 1;
		axw(rx_port_pkg::OFS_CTRL, 32'h0000_001C, rx_port_pkg::RESP_OKAY);
		settle(40);
		repeat (8400) @(posedge aclk);
		`CHK("pin seen", 1'b1, pin_seen)
		cmp_on <= 0;
		test_on <= 0;
		axw(rx_port_pkg::OFS_CTRL, 32'h0000_0018, rx_port_pkg::RESP_OKAY);
		rchk("pass event", rx_port_pkg::OFS_INT_STATUS, 32'h0000_0002, 32'h0000_0002);
		`CHK("irq masked", 1'b0, irq)
		axw(rx_port_pkg::OFS_INT_MASK, 32'h0000_0002, rx_port_pkg::RESP_OKAY);
		`CHK("irq raised", 1'b1, irq)
		axw(rx_port_pkg::OFS_INT_STATUS, 32'h0000_0002, rx_port_pkg::RESP_OKAY);
		`CHK("irq cleared", 1'b0, irq)
		foreach (fields[k]) begin
			axw(rx_port_pkg::OFS_CTRL, {29'h0000_0003, fields[k], 1'b0}, rx_port_pkg::RESP_OKAY);
			repeat (20) @(posedge aclk);
			`CHK("status pin", 1'b0, checker_status_pin)
		end
		$display("test checker done");
		train_on <= 0;
		repeat (40) @(posedge aclk);
		rchk("range lost", rx_port_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
		rchk("range event", rx_port_pkg::OFS_INT_STATUS, 32'h0000_0004, 32'h0000_0004);
		train_on <= 1;
		axw(rx_port_pkg::OFS_CTRL, 32'h0000_0001, rx_port_pkg::RESP_OKAY);
		aresetn <= 0;
		half <= 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rchk("ctrl again", rx_port_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0018);
		$display("test training and reset done");
		complete_run();
	end
endmodule : deser_rx_output_status_port_tb_top
